// file: logic/muldiv_defines.svh
/*
  Constants for the sliced multiply/divide datapath: widths, slice layout,
  step counts and reset values.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef MULDIV_DEFINES_SVH
`define MULDIV_DEFINES_SVH

`define DP_WIDTH      16
`define SLICE_WIDTH   4
`define SLICE_COUNT   4
`define REG_COUNT     16
`define ADDR_WIDTH    4
`define ZERO_WORD     16'h0000
`define ONE_WORD      16'h0001
`define UMUL_STEPS    5'h10
`define SMUL_STEPS    5'h0f
`define TOP_BIT       15

`endif

// file: logic/muldiv_pkg.sv
/*
  Types for the sliced multiply/divide datapath.
  Assumes muldiv_defines.svh is on the include path.
*/
`include "muldiv_defines.svh"

package muldiv_pkg;

  // Operation selected by the sequencer each microcycle.
  typedef enum logic [2:0] {
    OP_HOLD,
    OP_LOAD_REG,
    OP_LOAD_Q,
    OP_UMUL,
    OP_SMUL,
    OP_SMUL_LAST,
    OP_DIV_STEP,
    OP_DIV_CORRECT
  } op_t;

  // One microinstruction from the sequencer.
  typedef struct packed {
    op_t                      op;
    logic [`ADDR_WIDTH-1:0]   addrA;
    logic [`ADDR_WIDTH-1:0]   addrB;
    logic [`DP_WIDTH-1:0]     dataIn;
  } micro_t;

  // Status returned to the status/shift unit.
  typedef struct packed {
    logic carryOut;
    logic overflow;
    logic sign;
    logic zero;
  } status_t;

endpackage : muldiv_pkg

// file: logic/sliced_muldiv.sv
/*
  Sixteen-bit multiply/divide datapath of four cascaded 4-bit slices with a
  register file and a Q register. Assumes a sequencer issues one
  microinstruction each clock from the same clock domain, loads operands,
  counts steps and performs all divide scaling and abort decisions.
*/
`timescale 1ns/1ns
`default_nettype none
`include "muldiv_defines.svh"

module sliced_muldiv (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire muldiv_pkg::micro_t       micro,
  output var  logic [`DP_WIDTH-1:0]     resultB,
  output var  logic [`DP_WIDTH-1:0]     resultQ,
  output var  muldiv_pkg::status_t      status,
  output var  logic                     zeroPinOut,
  output var  logic                     zeroPinOe_n
);
  import muldiv_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [`DP_WIDTH-1:0] regFile [`REG_COUNT];
  logic [`DP_WIDTH-1:0] qReg;

  // One 4-bit slice adder; the chained carry links the slices in order.
  function automatic logic [`SLICE_WIDTH:0] sliceAdd(
    input logic [`SLICE_WIDTH-1:0] a,
    input logic [`SLICE_WIDTH-1:0] b,
    input logic                    cin
  );
    sliceAdd = {1'b0, a} + {1'b0, b} + {{`SLICE_WIDTH{1'b0}}, cin};
  endfunction : sliceAdd

  // ----------------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------------
  wire logic [`DP_WIDTH-1:0] opA = regFile[micro.addrA];
  wire logic [`DP_WIDTH-1:0] opB = regFile[micro.addrB];
  wire logic isUmul = (micro.op == OP_UMUL);
  wire logic isSmul = (micro.op == OP_SMUL);
  wire logic isLast = (micro.op == OP_SMUL_LAST);
  wire logic isDiv  = (micro.op == OP_DIV_STEP) ||
                      (micro.op == OP_DIV_CORRECT);
  wire logic isMul  = isUmul || isSmul || isLast;

  // The shared zero line carries the multiplier LSB from the lowest slice.
  wire logic zeroLine = qReg[0];
  // Divide: signs differ means add the divisor, else subtract.
  wire logic signsDiffer = opB[`TOP_BIT] ^ opA[`TOP_BIT];

  // Divide: the first step compares signs, later steps reuse the last
  // quotient bit, because the shifted remainder can lose its sign bit.
  logic divRun;
  wire logic divSub = divRun ? qReg[0] : !signsDiffer;
  // Add on zero line in multiply; subtract on last step with negative sign.
  wire logic doSub = (isLast && zeroLine) || (isDiv && divSub);
  wire logic useA  = isDiv || ((isUmul || isSmul || isLast) && zeroLine);
  wire logic [`DP_WIDTH-1:0] addend =
    useA ? (doSub ? ~opA : opA) : `ZERO_WORD;
  // Carry-in is low for UMUL and SMUL steps; high only to complete a subtraction.
  wire logic carryIn = doSub;

  // ----------------------------------------------------------------------
  // Four cascaded slices
  // ----------------------------------------------------------------------
  logic [`SLICE_COUNT:0]     carryChain;
  logic [`DP_WIDTH-1:0]      aluOut;
  assign carryChain[0] = carryIn;
  for (genvar s = 0; s < `SLICE_COUNT; s++) begin : g_slice
    wire logic [`SLICE_WIDTH:0] sum = sliceAdd(
      opB[s*`SLICE_WIDTH +: `SLICE_WIDTH],
      addend[s*`SLICE_WIDTH +: `SLICE_WIDTH],
      carryChain[s]);
    assign aluOut[s*`SLICE_WIDTH +: `SLICE_WIDTH] = sum[`SLICE_WIDTH-1:0];
    assign carryChain[s+1] = sum[`SLICE_WIDTH];
  end

  wire logic carryTop = carryChain[`SLICE_COUNT];
  wire logic signTop  = aluOut[`TOP_BIT];
  // Overflow from operand and result signs; the carry into bit 15 is
  // buried inside the top slice and not visible on the slice chain.
  wire logic ovrTop   = (opB[`TOP_BIT] ~^ addend[`TOP_BIT]) &
                        (opB[`TOP_BIT] ^ signTop);

  // Bit entering the top output bit of the most significant slice.
  wire logic topFill = isUmul ? carryTop : (signTop ^ ovrTop);

  // Down shift: RAM shift low port of slice one feeds Q shift high port.
  wire logic [`DP_WIDTH-1:0] mulB = {topFill, aluOut[`TOP_BIT:1]};
  wire logic [`DP_WIDTH-1:0] mulQ = {aluOut[0], qReg[`TOP_BIT:1]};

  // Divide: quotient bit is one when the new remainder sign matches divisor.
  wire logic qBit = ~(signTop ^ opA[`TOP_BIT]);
  // Up shift of the 32-bit remainder/quotient pair; Q MSB feeds RAM LSB.
  wire logic [`DP_WIDTH-1:0] divB = {aluOut[`TOP_BIT-1:0], qReg[`TOP_BIT]};
  // Correction forces the final quotient bit to one as bias correction.
  wire logic lastQ = (micro.op == OP_DIV_CORRECT) ? 1'b1 : qBit;
  wire logic [`DP_WIDTH-1:0] divQ = {qReg[`TOP_BIT-1:0], lastQ};
  // The correction step keeps the remainder unshifted, scaled by 2^(n-1).
  wire logic [`DP_WIDTH-1:0] corrB = aluOut;

  // ----------------------------------------------------------------------
  // Next-state selection
  // ----------------------------------------------------------------------
  logic [`DP_WIDTH-1:0] next_b;
  logic [`DP_WIDTH-1:0] next_q;
  logic                 writeB;
  always_comb begin
    next_b = opB;
    next_q = qReg;
    writeB = 1'b0;
    unique case (micro.op)
      OP_HOLD:        begin end
      OP_LOAD_REG:    begin
        next_b = micro.dataIn;
        writeB = 1'b1;
      end
      OP_LOAD_Q:      next_q = opA;
      OP_UMUL, OP_SMUL: begin
        next_b = mulB;
        next_q = mulQ;
        writeB = 1'b1;
      end
      OP_SMUL_LAST:   begin
        // Final adjust keeps the sign-extension shift of signed steps.
        next_b = mulB;
        next_q = mulQ;
        writeB = 1'b1;
      end
      OP_DIV_STEP:    begin
        next_b = divB;
        next_q = divQ;
        writeB = 1'b1;
      end
      OP_DIV_CORRECT: begin
        next_b = corrB;
        next_q = divQ;
        writeB = 1'b1;
      end
    endcase
  end

  // Register file write; only the B-addressed word changes.
  always_ff @(posedge clk) begin
    if (writeB) begin
      regFile[micro.addrB] <= next_b;
    end
  end

  // Q register and outputs; outputs are registered for clean timing.
  always_ff @(posedge clk) begin
    if (rst) begin
      qReg        <= `ZERO_WORD;
      resultB     <= `ZERO_WORD;
      resultQ     <= `ZERO_WORD;
      status      <= '0;
      zeroPinOut  <= 1'b0;
      zeroPinOe_n <= 1'b1;
      divRun      <= 1'b0;
    end else begin
      qReg        <= next_q;
      resultB     <= next_b;
      resultQ     <= next_q;
      status      <= '{carryOut: carryTop, overflow: ovrTop,
                       sign: signTop, zero: (aluOut == `ZERO_WORD)};
      zeroPinOut  <= next_q[0];
      zeroPinOe_n <= ~(next_isMul(micro.op));
      divRun      <= (micro.op == OP_DIV_STEP);
    end
  end

  // Lowest slice keeps driving its zero pin for the following multiply step.
  function automatic logic next_isMul(input op_t op);
    next_isMul = (op == OP_UMUL) || (op == OP_SMUL) || (op == OP_LOAD_Q);
  endfunction : next_isMul

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Reference 17-bit sum, sign-extended, for the true sign of each step.
  wire logic [`DP_WIDTH:0] wideSum = {opB[`TOP_BIT], opB} +
    {addend[`TOP_BIT], addend} + {{`DP_WIDTH{1'b0}}, carryIn};

  a_zero_pin_lsb: assert property (@(posedge clk) disable iff (rst)
    (isUmul || isSmul) |=> !zeroPinOe_n && zeroPinOut == $past(qReg[1]))
    else $error("zero pin does not follow multiplier lsb");

  a_umul_shift: assert property (@(posedge clk) disable iff (rst)
    isUmul |=> resultB == {$past(carryTop), $past(aluOut[`TOP_BIT:1])})
    else $error("unsigned step did not shift sum down");

  a_umul_add: assert property (@(posedge clk) disable iff (rst)
    isUmul && !zeroLine |-> aluOut == opB)
    else $error("partial product changed with zero line low");

  a_smul_fill: assert property (@(posedge clk) disable iff (rst)
    (isSmul || isLast) |=> resultB[`TOP_BIT] == $past(wideSum[`DP_WIDTH]))
    else $error("signed step top bit wrong");

  a_last_sub: assert property (@(posedge clk) disable iff (rst)
    isLast && !qReg[0] |-> aluOut == opB)
    else $error("positive multiplier sign altered product");

  a_q_chain: assert property (@(posedge clk) disable iff (rst)
    isMul |=> resultQ == {$past(aluOut[0]), $past(qReg[`TOP_BIT:1])})
    else $error("q shift chain broken");

  a_div_bias: assert property (@(posedge clk) disable iff (rst)
    micro.op == OP_DIV_CORRECT |=> resultQ[0])
    else $error("final quotient bit not forced");

  a_slice_carry: assert property (@(posedge clk) disable iff (rst)
    isUmul |-> {carryTop, aluOut} == {1'b0, opB} + {1'b0, addend})
    else $error("slice carry chain wrong");

endmodule : sliced_muldiv
`default_nettype wire

// file: bench/muldiv_sequencer.sv
/*
  Sequencer model that issues one microinstruction each cycle.
  Assumes the bench calls its tasks 1 ns after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module muldiv_sequencer (
  input  wire logic               clk,
  output var  muldiv_pkg::micro_t micro
);
  import muldiv_pkg::*;
  // ------------------------------------------------------------------
  // Issue helpers
  // ------------------------------------------------------------------
  initial micro = '0;
  // Fields stand until the edge that takes them.
  task automatic step(input op_t op, input logic [3:0] a, b,
                      input logic [15:0] d = 16'h0000);
    micro = '{op, a, b, d};
    @(posedge clk);
    #1;
  endtask : step
  // Magnitude of a two's complement word.
  function automatic logic [15:0] mag(input logic [15:0] v);
    return v[15] ? -v : v;
  endfunction : mag
  // Operands live in R0 (multiplicand), R15 (multiplier), R1 (partial).
  task automatic mul(input logic s, input logic [15:0] x, y);
    step(OP_LOAD_REG, 4'h0, 4'h0, x);
    step(OP_LOAD_REG, 4'h0, 4'hf, y);
    step(OP_LOAD_REG, 4'h0, 4'h1);
    step(OP_LOAD_Q, 4'hf, 4'h1);
    repeat (s ? 15 : 16) step(s ? OP_SMUL : OP_UMUL, 4'h0, 4'h1);
    if (s) step(OP_SMUL_LAST, 4'h0, 4'h1);
    repeat (2) step(OP_HOLD, 4'h0, 4'h1);
  endtask : mul
  // Divisor R0, dividend halves R1 and R4; a zero divisor aborts.
  task automatic div(input logic [15:0] hi, lo, dv);
    if (dv == 16'h0000) return;
    if (hi == 16'h8000) {hi, lo} = {hi[15], hi, lo[15:1]};
    if (mag(dv) <= mag(hi) && dv != 16'h8000) return;
    step(OP_LOAD_REG, 4'h0, 4'h0, dv);
    step(OP_LOAD_REG, 4'h0, 4'h1, hi);
    step(OP_LOAD_REG, 4'h0, 4'h4, lo);
    step(OP_LOAD_Q, 4'h4, 4'h1);
    repeat (15) step(OP_DIV_STEP, 4'h0, 4'h1);
    step(OP_DIV_CORRECT, 4'h0, 4'h1);
    repeat (2) step(OP_HOLD, 4'h0, 4'h1);
  endtask : div
endmodule : muldiv_sequencer
`default_nettype wire

// file: bench/sliced_multiply_divide_datapath_tb_top.sv
/*
  Self-checking bench for the sliced multiply/divide datapath.
  Assumes the sequencer model drives micro and the bench drives rst.
*/
`timescale 1ns/1ns
`default_nettype none
module sliced_multiply_divide_datapath_tb_top;
  import muldiv_pkg::*;
  logic        clk;
  logic        rst;
  micro_t      micro;
  logic [15:0] resultB;
  logic [15:0] resultQ;
  status_t     status;
  logic        zeroPinOut;
  logic        zeroPinOe_n;
  logic        prevUmul;
  logic [15:0] hi;
  logic [15:0] dv;
  int          errors;
  int          n_compared;
  // ------------------------------------------------------------------
  // Structure
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  muldiv_sequencer seq (.clk(clk), .micro(micro));
  sliced_muldiv dut (.clk(clk), .rst(rst), .micro(micro),
    .resultB(resultB), .resultQ(resultQ), .status(status),
    .zeroPinOut(zeroPinOut), .zeroPinOe_n(zeroPinOe_n));
  // ------------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // Sign-extend when signed, so one product covers both modes.
  function automatic logic [31:0] prod(input logic s, input logic [15:0] x, y);
    return {{16{s & x[15]}}, x} * {{16{s & y[15]}}, y};
  endfunction : prod
  task automatic mul_test(input logic s, input logic [15:0] x, y);
    logic [31:0] p;
    p = prod(s, x, y);
    seq.mul(s, x, y);
    chk({resultB, resultQ}, p);
    chk({31'h0, zeroPinOut}, p & 32'h1);
    chk({28'h0, status}, {30'h0, p[31], p[31:16] == 16'h0000});
  endtask : mul_test
  task automatic div_test(input logic [15:0] h, l, d);
    logic [31:0] rebuilt;
    seq.div(h, l, d);
    rebuilt = $signed(d) * $signed(resultQ) + $signed(resultB);
    chk(rebuilt, $signed({h, l}) >>> 1);
    chk({31'h0, resultQ[0]}, 32'h1);
    chk({31'h0, resultQ[15]}, {31'h0, h[15] ^ d[15]});
    chk({31'h0, seq.mag(resultB) <= seq.mag(d)}, 32'h1);
  endtask : div_test
  // The zero pin must drive in the cycle after each unsigned step.
  always @(posedge clk) prevUmul <= (micro.op == OP_UMUL);
  always @(negedge clk) if (prevUmul === 1'b1) chk({31'h0, zeroPinOe_n}, 32'h0);
  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    #100000;
    errors++;
    end_sim();
  end
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    errors = 0;
    n_compared = 0;
    void'($urandom(80177));
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({resultB, resultQ}, 32'h0);
    chk({31'h0, zeroPinOe_n}, 32'h1);
    // Boundary operands first, then random ones.
    mul_test(1'b0, 16'hffff, 16'hffff);
    mul_test(1'b0, 16'h0000, 16'h1234);
    mul_test(1'b1, 16'h8000, 16'h8000);
    mul_test(1'b1, 16'h7fff, 16'h8000);
    mul_test(1'b1, 16'hffff, 16'hffff);
    repeat (8) mul_test(1'b0, 16'($urandom), 16'($urandom));
    repeat (8) mul_test(1'b1, 16'($urandom), 16'($urandom));
    $display("multiply tests done");
    div_test(16'hc000, 16'h1234, 16'h8000);
    repeat (8) begin
      do begin
        hi = 16'($urandom);
        dv = 16'($urandom);
      end while (!(seq.mag(hi) >= 16'h0100 && seq.mag(dv) > seq.mag(hi)));
      div_test(hi, 16'($urandom), dv);
    end
    $display("divide tests done");
    end_sim();
  end
endmodule : sliced_multiply_divide_datapath_tb_top
`default_nettype wire
